/* File: src/mu_pkg.sv */
// Shared constants for the math unit host access block.
// Assumes a single 40 MHz clock domain.
package mu_pkg;
   localparam int DATA_W = 32;
   localparam int RES_W  = 96;
   localparam int OBJ_W  = 3;
   localparam int NREGS  = 4;

   // Object select, taken from address bits 4..2
   localparam int         ADDR_OBJ_LSB = 2;
   localparam logic [2:0] OBJ_STATUS   = 3'h0;
   localparam logic [2:0] OBJ_RES_HI   = 3'h1;
   localparam logic [2:0] OBJ_RES_MID  = 3'h2;
   localparam logic [2:0] OBJ_RES_LO   = 3'h3;
   localparam logic [2:0] OBJ_CMD      = 3'h7;

   // Command word fields
   localparam int OP_LSB      = 9;
   localparam int OP_W        = 5;
   localparam int SRC_REG_BIT = 8;
   localparam int SRC_IDX_LSB = 6;
   localparam int DST_REG_BIT = 5;
   localparam int DST_IDX_LSB = 3;

   localparam logic [4:0] OP_MOVE  = 5'h07;
   localparam logic [4:0] OP_STRD  = 5'h08;
   localparam logic [4:0] OP_STWR  = 5'h09;

   // Status bit that makes an interrupt force the quiescent state
   localparam int                ABORT_INTR_BIT = 30;
   localparam logic [DATA_W-1:0] STATUS_RESET   = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CMD_RESET      = 32'h0000_0000;
   localparam logic [RES_W-1:0]  RES_RESET      = 96'h0;
   localparam int                SYNC_STAGES   = 2;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_STORE} mu_state_type;
endpackage

/* File: src/mu_opregs.sv */
// Four-entry operand register file of the math unit.
// Assumes one writer and one reader on ref_clk; read data is registered.
`timescale 1ns/1ps
module mu_opregs #(
   parameter int W = 96,
   parameter int N = 4
) (
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 wr_en,
   input  wire logic [$clog2(N)-1:0] wr_idx,
   input  wire logic [W-1:0]         wr_data,
   input  wire logic                 rd_en,
   input  wire logic [$clog2(N)-1:0] rd_idx,
   output logic      [W-1:0]         rd_data
);
   logic [W-1:0] mem [N];

   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_idx];
      end
   end
endmodule

/* File: src/mu_access.sv */
// Math unit host access port: memory mapped objects, transaction sequencer, abort.
// Assumes bus pins arrive asynchronously and are synchronised here.
// How it works
// - Every mapped access ends with a normal acknowledge, never a fault.
// - Access is taken on data read or write with chip select; address latched.
// - Address bits 4..2 pick status, one of three result words, or command.
// - Reads return the selected object; writes store bus data into it.
// - Status and result are read/write; command is write only.
// - Operand registers have no address; moves alone reach them.
// - Every access is a full word; reads return a whole word.
// - Narrow writes update the full word; host should write words.
// - Peripheral mode ignores interrupt acknowledge and keeps running.
// - Peripheral mode: interrupt with abort bit set forces the quiescent state.
// - Coprocessor mode: interrupt before completion aborts the operation.
// - A restart runs from the start, regardless of leftover status.
// - Coprocessor mode: a faulted later result store aborts the operation.
// - Reading the result register leaves it unchanged.
// - Move to memory places the value in the result register.
// - Quiescent: data accesses still served, no internal register activity.
// - After a command write, interrupt acknowledges are ignored in peripheral mode; in coprocessor mode they abort.
`timescale 1ns/1ps
module mu_access (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        chip_sel_n,
   input  wire logic        data_rd,
   input  wire logic        data_wr,
   input  wire logic [31:0] bus_addr,
   input  wire logic [3:0]  byte_en,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        cp_mode,
   input  wire logic        intr_req,
   input  wire logic        intr_ack,
   input  wire logic        store_fault,
   output logic      [31:0] bus_rdata,
   output logic             bus_oe_n,
   output logic             bus_ack,
   output logic             bus_fault,
   output logic             op_done_n
);
   // Seven control pins, the object field and the write data share one synchroniser
   localparam int SW = 7 + mu_pkg::OBJ_W + mu_pkg::DATA_W;

   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic          s_cs_n, s_rd, s_wr, s_cpm, s_intr, s_iack, s_sfault;
   logic [2:0]    s_obj;
   logic [31:0]   s_wdata;
   logic          acc, acc_q, acc_start;
   logic          serve_q, acc_wr_q;
   logic [2:0]    obj_q;
   logic [31:0]   wdata_q;
   logic [31:0]   read_mux;
   logic          bus_wr_fire, cmd_start;
   logic [31:0]   status_q, cmd_q;
   logic [95:0]   result_q;
   mu_pkg::mu_state_type st_q;
   logic          busy, abort_now;
   logic [4:0]    op;
   logic          rf_rd_en, rf_wr_en;
   logic [95:0]   rf_rdata, move_val;
   logic          store_ok;

   // Byte enables are not used: every access is a whole word
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sync1_q <= '1;
         sync2_q <= '1;
      end else begin
         sync1_q <= {chip_sel_n, data_rd, data_wr, cp_mode, intr_req, intr_ack,
                     store_fault, bus_addr[4:2], bus_wdata};
         sync2_q <= sync1_q;
      end
   end

   assign {s_cs_n, s_rd, s_wr, s_cpm, s_intr, s_iack, s_sfault, s_obj, s_wdata} = sync2_q;
   assign acc       = !s_cs_n && (s_rd || s_wr);
   assign acc_start = acc && !acc_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         acc_q    <= 1'b0;
         serve_q  <= 1'b0;
         acc_wr_q <= 1'b0;
         obj_q    <= 3'h0;
         wdata_q  <= 32'h0000_0000;
      end else begin
         acc_q   <= acc;
         serve_q <= acc_start;
         if (acc_start) begin
            obj_q    <= s_obj;
            acc_wr_q <= s_wr;
            wdata_q  <= s_wdata;
         end
      end
   end

   // Unmapped objects and the command register read as zero
   always_comb begin
      if (obj_q == mu_pkg::OBJ_STATUS) begin
         read_mux = status_q;
      end else if (obj_q == mu_pkg::OBJ_RES_HI) begin
         read_mux = result_q[95:64];
      end else if (obj_q == mu_pkg::OBJ_RES_MID) begin
         read_mux = result_q[63:32];
      end else if (obj_q == mu_pkg::OBJ_RES_LO) begin
         read_mux = result_q[31:0];
      end else begin
         read_mux = 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bus_rdata <= 32'h0000_0000;
         bus_oe_n  <= 1'b1;
         bus_ack   <= 1'b0;
      end else begin
         if (!acc) begin
            bus_oe_n <= 1'b1;
            bus_ack  <= 1'b0;
         end
         if (serve_q && acc) begin
            bus_ack <= 1'b1;
            if (!acc_wr_q) begin
               bus_rdata <= read_mux;
               bus_oe_n  <= 1'b0;
            end
         end
      end
   end

   assign bus_fault   = 1'b0;
   assign bus_wr_fire = serve_q && acc && acc_wr_q;
   assign cmd_start   = bus_wr_fire && obj_q == mu_pkg::OBJ_CMD;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_q <= mu_pkg::CMD_RESET;
      end else if (cmd_start) begin
         cmd_q <= wdata_q;
      end
   end

   // Interrupt acknowledge never aborts in peripheral mode
   assign busy      = st_q != mu_pkg::ST_IDLE;
   assign abort_now = busy && (s_cpm ? (s_intr || s_iack || s_sfault)
                      : (s_intr && status_q[mu_pkg::ABORT_INTR_BIT]));
   assign op        = cmd_q[mu_pkg::OP_LSB +: mu_pkg::OP_W];
   assign store_ok  = st_q == mu_pkg::ST_STORE && !abort_now;

   // A new command always restarts from fetch; no state survives an abort
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q      <= mu_pkg::ST_IDLE;
         op_done_n <= 1'b0;
      end else if (cmd_start) begin
         st_q      <= mu_pkg::ST_FETCH;
         op_done_n <= 1'b1;
      end else if (abort_now) begin
         st_q      <= mu_pkg::ST_IDLE;
         op_done_n <= 1'b0;
      end else begin
         case (st_q)
            mu_pkg::ST_FETCH: begin
               st_q <= mu_pkg::ST_STORE;
            end
            mu_pkg::ST_STORE: begin
               st_q      <= mu_pkg::ST_IDLE;
               op_done_n <= 1'b0;
            end
            default: begin
               st_q <= mu_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign rf_rd_en = st_q == mu_pkg::ST_FETCH;
   assign move_val = cmd_q[mu_pkg::SRC_REG_BIT] ? rf_rdata : result_q;
   assign rf_wr_en = store_ok && op == mu_pkg::OP_MOVE && cmd_q[mu_pkg::DST_REG_BIT];

   mu_opregs #(
      .W (mu_pkg::RES_W),
      .N (mu_pkg::NREGS)
   ) u_opregs (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .wr_en   (rf_wr_en),
      .wr_idx  (cmd_q[mu_pkg::DST_IDX_LSB +: 2]),
      .wr_data (move_val),
      .rd_en   (rf_rd_en),
      .rd_idx  (cmd_q[mu_pkg::SRC_IDX_LSB +: 2]),
      .rd_data (rf_rdata)
   );

   // Bus writes win over the sequencer; the host never overlaps them
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         status_q <= mu_pkg::STATUS_RESET;
      end else if (bus_wr_fire && obj_q == mu_pkg::OBJ_STATUS) begin
         status_q <= wdata_q;
      end else if (store_ok && op == mu_pkg::OP_STWR) begin
         status_q <= result_q[31:0];
      end
   end

   // Reads never touch the result register, so a restarted read sees the same word
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         result_q <= mu_pkg::RES_RESET;
      end else if (bus_wr_fire && obj_q == mu_pkg::OBJ_RES_HI) begin
         result_q[95:64] <= wdata_q;
      end else if (bus_wr_fire && obj_q == mu_pkg::OBJ_RES_MID) begin
         result_q[63:32] <= wdata_q;
      end else if (bus_wr_fire && obj_q == mu_pkg::OBJ_RES_LO) begin
         result_q[31:0] <= wdata_q;
      end else if (store_ok && op == mu_pkg::OP_MOVE && !cmd_q[mu_pkg::DST_REG_BIT]) begin
         result_q <= move_val;
      end else if (store_ok && op == mu_pkg::OP_STRD) begin
         result_q[31:0] <= status_q;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   AST_NO_FAULT: assert property (bus_ack |-> !bus_fault)
      else $error("fault shown on a mapped access");
   AST_ACK_TWO_AFTER: assert property (acc_start ##1 acc |=> bus_ack)
      else $error("access not acknowledged two cycles after start");
   AST_OE_NEEDS_CS: assert property (!bus_oe_n |-> $past(acc))
      else $error("bus driven without selected access");
   AST_READ_RES_LO: assert property (
      serve_q && acc && !acc_wr_q && obj_q == mu_pkg::OBJ_RES_LO
      |=> !bus_oe_n && bus_rdata == $past(result_q[31:0]))
      else $error("low result word not returned");
   AST_CMD_READS_ZERO: assert property (
      serve_q && acc && !acc_wr_q && obj_q == mu_pkg::OBJ_CMD
      |=> bus_rdata == 32'h0000_0000)
      else $error("command register readable");
   AST_RES_READ_KEEPS: assert property (
      serve_q && !acc_wr_q && !busy && !cmd_start
      |=> $stable(result_q))
      else $error("result changed by a read");
   AST_WORD_WRITE: assert property (
      bus_wr_fire && obj_q == mu_pkg::OBJ_RES_MID
      |=> result_q[63:32] == $past(wdata_q))
      else $error("result word not written whole");
   AST_PERIPH_KEEPS: assert property (
      st_q == mu_pkg::ST_FETCH && !s_cpm && !s_intr && !cmd_start
      |=> st_q == mu_pkg::ST_STORE)
      else $error("peripheral transaction stopped");
   AST_INTR_ABORT: assert property (
      busy && !s_cpm && s_intr && status_q[mu_pkg::ABORT_INTR_BIT] && !cmd_start
      |=> st_q == mu_pkg::ST_IDLE && !op_done_n)
      else $error("no quiescent state after interrupt");
   AST_CP_ABORT: assert property (
      busy && s_cpm && s_intr && !cmd_start
      |-> !rf_wr_en ##1 st_q == mu_pkg::ST_IDLE)
      else $error("coprocessor interrupt did not abort");
   AST_DONE_RISES: assert property (
      cmd_start |=> op_done_n && st_q == mu_pkg::ST_FETCH)
      else $error("command did not start a transaction");
   AST_MOVE_RES: assert property (
      store_ok && op == mu_pkg::OP_MOVE && !cmd_q[mu_pkg::DST_REG_BIT]
      && !bus_wr_fire |=> result_q == $past(move_val))
      else $error("move result missing from result register");
   AST_QUIET: assert property (st_q == mu_pkg::ST_IDLE |-> !rf_rd_en && !rf_wr_en)
      else $error("operand registers touched while quiescent");

   COV_READ: cover property (serve_q && acc && !acc_wr_q);
   COV_MOVE_DONE: cover property (store_ok && op == mu_pkg::OP_MOVE);
   COV_ABORT: cover property (abort_now);
endmodule

/* File: sim/mu_host_model.sv */
// Host bus model: chip-selected word accesses held until acknowledge.
// Assumes the unit acknowledges each selected access and drops it after release.
`timescale 1ns/1ps
module mu_host_model (
   input  wire logic        ref_clk,
   input  wire logic        bus_ack,
   output logic             chip_sel_n,
   output logic             data_rd,
   output logic             data_wr,
   output logic      [31:0] bus_addr,
   output logic      [3:0]  byte_en,
   output logic      [31:0] bus_wdata
);
   initial begin
      chip_sel_n = 1'b1;
      data_rd    = 1'b0;
      data_wr    = 1'b0;
      bus_addr   = 32'h0;
      byte_en    = 4'hF;
      bus_wdata  = 32'h0;
   end
   // Released address and data lines show the inverse of the last value, never a stale copy
   task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                         input logic [3:0] be);
      int n;
      @(negedge ref_clk);
      chip_sel_n = 1'b0;
      data_rd    = !wr;
      data_wr    = wr;
      bus_addr   = addr;
      bus_wdata  = data;
      byte_en    = be;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (bus_ack !== 1'b1 && n < 40);
      @(negedge ref_clk);
      chip_sel_n = 1'b1;
      data_rd    = 1'b0;
      data_wr    = 1'b0;
      bus_addr   = ~bus_addr;
      bus_wdata  = ~bus_wdata;
      n = 0;
      while (bus_ack !== 1'b0 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   // Write strobe with the unit not selected
   task automatic stray(input logic [31:0] data);
      @(negedge ref_clk);
      data_wr   = 1'b1;
      bus_wdata = data;
      repeat (8) @(negedge ref_clk);
      data_wr   = 1'b0;
      bus_wdata = ~data;
   endtask
endmodule

/* File: sim/tb_top.sv */
// Bench for the math unit host port: registers, moves, aborts, deselected cycles.
// Assumes the host model drives the bus; read results are checked from a queue.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((ex) !== (got)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
   logic ref_clk, sys_rst, chip_sel_n, data_rd, data_wr, cp_mode, intr_req, intr_ack;
   logic store_fault, bus_oe_n, bus_ack, bus_fault, op_done_n, ack_seen;
   logic [31:0] bus_addr, bus_wdata, bus_rdata, a, ev;
   logic [3:0]  byte_en;
   logic [15:0] lfsr_q = 16'hD581;
   logic [95:0] f[4];
   logic [95:0] v, w;
   logic [5:0]  t;
   logic [5:0]  tbl[6] = '{6'h31, 6'h08, 6'h13, 6'h25, 6'h29, 6'h10};
   logic [31:0] exp_q[$];
   int n_errors = 0, compares = 0, cycles = 0;
   mu_access mu_access_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
      .data_rd(data_rd), .data_wr(data_wr), .bus_addr(bus_addr), .byte_en(byte_en),
      .bus_wdata(bus_wdata), .cp_mode(cp_mode), .intr_req(intr_req), .intr_ack(intr_ack),
      .store_fault(store_fault), .bus_rdata(bus_rdata), .bus_oe_n(bus_oe_n),
      .bus_ack(bus_ack), .bus_fault(bus_fault), .op_done_n(op_done_n));
   mu_host_model mu_host_model_inst (.ref_clk(ref_clk), .bus_ack(bus_ack),
      .chip_sel_n(chip_sel_n), .data_rd(data_rd), .data_wr(data_wr), .bus_addr(bus_addr),
      .byte_en(byte_en), .bus_wdata(bus_wdata));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      logic [31:0] r;
      for (int i = 0; i < 32; i++) begin
         lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
         r[i] = lfsr_q[0];
      end
      return r;
   endfunction
   // Random ignored address bits around the object field
   function automatic logic [31:0] adr(input logic [2:0] obj);
      logic [31:0] r;
      r = rnd();
      return {r[31:5], obj, r[1:0]};
   endfunction
   function automatic logic [31:0] mv(input logic sr, input logic [1:0] si, input logic dd,
                                      input logic [1:0] di);
      return {18'h0, mu_pkg::OP_MOVE, sr, si, dd, di, 3'h0};
   endfunction
   task automatic wr(input logic [2:0] obj, input logic [31:0] d);
      mu_host_model_inst.access(1'b1, adr(obj), d, 4'hF);
   endtask
   task automatic rd(input logic [2:0] obj, input logic [31:0] e);
      exp_q.push_back(e);
      mu_host_model_inst.access(1'b0, adr(obj), ~e, 4'hF);
   endtask
   task automatic put_res(input logic [95:0] d);
      wr(mu_pkg::OBJ_RES_HI, d[95:64]);
      wr(mu_pkg::OBJ_RES_MID, d[63:32]);
      wr(mu_pkg::OBJ_RES_LO, d[31:0]);
   endtask
   task automatic get_res(input logic [95:0] e);
      rd(mu_pkg::OBJ_RES_HI, e[95:64]);
      rd(mu_pkg::OBJ_RES_MID, e[63:32]);
      rd(mu_pkg::OBJ_RES_LO, e[31:0]);
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Result watcher: each new acknowledge of a read takes the oldest note
   always @(posedge ref_clk) begin
      if (bus_ack === 1'b1 && ack_seen !== 1'b1) begin
         `CHK("fault", 1'b0, bus_fault)
         if (bus_oe_n === 1'b0) begin
            ev = exp_q.pop_front();
            `CHK("rdata", ev, bus_rdata)
         end
      end
      ack_seen <= bus_ack;
      cycles++;
      if (cycles == 6000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      sys_rst = 1'b1;
      {cp_mode, intr_req, intr_ack, store_fault} = 4'h0;
      repeat (10) @(negedge ref_clk);
      `CHK("reset", 3'h4, {bus_oe_n, bus_ack, op_done_n})
      sys_rst = 1'b0;
      a = rnd() & 32'hBFFF_FFFF;
      wr(mu_pkg::OBJ_STATUS, a);
      rd(mu_pkg::OBJ_STATUS, a);
      v = {rnd(), rnd(), rnd()};
      put_res(v);
      get_res(v);
      get_res(v);
      rd(mu_pkg::OBJ_CMD, 32'h0);
      for (int o = 4; o < 7; o++) rd(3'(o), 32'h0);
      w[31:0] = rnd();
      mu_host_model_inst.access(1'b1, adr(mu_pkg::OBJ_RES_LO), w[31:0], 4'h1);
      rd(mu_pkg::OBJ_RES_LO, w[31:0]);
      fork
         mu_host_model_inst.stray(rnd());
         repeat (8) begin
            @(posedge ref_clk);
            `CHK("idle", 2'h2, {bus_oe_n, bus_ack})
         end
      join
      rd(mu_pkg::OBJ_RES_LO, w[31:0]);
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         f[k] = {rnd(), rnd(), rnd()};
         put_res(f[k]);
         wr(mu_pkg::OBJ_CMD, mv(1'b0, 2'h0, 1'b1, 2'(k)));
      end
      for (int k = 0; k < 4; k++) begin
         wr(mu_pkg::OBJ_CMD, mv(1'b1, 2'(k), 1'b0, 2'h0));
         get_res(f[k]);
      end
      wr(mu_pkg::OBJ_CMD, {18'h0, mu_pkg::OP_STRD, 9'h0});
      rd(mu_pkg::OBJ_RES_LO, a);
      wr(mu_pkg::OBJ_RES_LO, ~a);
      wr(mu_pkg::OBJ_CMD, {18'h0, mu_pkg::OP_STWR, 9'h0});
      rd(mu_pkg::OBJ_STATUS, ~a);
      $display("test moves done");
      // Cases: cp intr, periph ack, periph intr with abort bit, cp fault, cp ack, periph intr
      for (int c = 0; c < 6; c++) begin
         t = tbl[c];
         v = {rnd(), rnd(), rnd()};
         put_res(v);
         wr(mu_pkg::OBJ_CMD, mv(1'b0, 2'h0, 1'b1, 2'h0));
         wr(mu_pkg::OBJ_STATUS, {1'b0, t[1], 30'h0});
         {cp_mode, intr_req, intr_ack, store_fault} = t[5:2];
         repeat (4) @(negedge ref_clk);
         w = {rnd(), rnd(), rnd()};
         put_res(w);
         wr(mu_pkg::OBJ_CMD, mv(1'b0, 2'h0, 1'b1, 2'h0));
         `CHK("done", 1'b0, op_done_n)
         {cp_mode, intr_req, intr_ack, store_fault} = 4'h0;
         repeat (4) @(negedge ref_clk);
         wr(mu_pkg::OBJ_CMD, mv(1'b1, 2'h0, 1'b0, 2'h0));
         get_res(t[0] ? v : w);
         wr(mu_pkg::OBJ_STATUS, 32'h0);
      end
      $display("test aborts done");
      repeat (10) @(negedge ref_clk);
      `CHK("pending reads", 0, exp_q.size())
      report_and_stop();
   end
endmodule
